// ==== rtl/irq_controller.sv ====
// Interrupt controller of a small 8-bit core: flags, enables, vectoring and wake-up.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module irq_controller
	import irq_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_irq_pin,
	input wire logic [3:0] port_b_pins,
	input wire logic port_b_read,
	input wire logic timer_rollover,
	input wire logic comparator_evt,
	input wire logic serial_tx_evt,
	input wire logic serial_rx_evt,
	input wire logic capture_compare_evt,
	input wire logic timer_b_overflow_evt,
	input wire logic timer_match_evt,
	input wire logic eeprom_done_evt,
	input wire logic irq_disable_instr,
	input wire logic return_from_irq_instr,
	input wire logic sleeping,
	input wire logic [12:0] return_pc,
	output logic q_end,
	output logic irq_take,
	output logic [12:0] vector_pc,
	output logic [12:0] pushed_pc,
	output logic push_stack,
	output logic nop_slot,
	output logic wake
);
	logic [7:0] irq_control_r;
	logic [7:0] periph_flag_reg_r;
	logic [7:0] periph_enable_reg_r;
	logic [7:0] option_r;
	logic [1:0] q_r;
	logic [3:0] port_latch_r;
	logic ext_level;
	logic ext_rise;
	logic ext_fall;
	logic [3:0] port_sync;
	logic ext_edge;
	logic ext_pend_r;
	logic port_change;
	logic core_req;
	logic periph_req;
	logic pending;
	logic pend_d1_r;
	logic nop_r;
	logic [7:0] ctrl_set;
	logic [7:0] periph_set;
	logic [7:0] rdata_r;
	logic [12:0] vector_r;
	logic [12:0] pushed_r;
	logic take_r;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_WAIT = 2'b01,
		ST_ENTER = 2'b10
	} irq_state_t;
	irq_state_t state_r;
	irq_state_t state_nxt;

	// Write-strobe decode for one register offset.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
		hit = s && (a == ofs);
	endfunction

	// Pin input synchroniser and edge detector for the external interrupt pin.
	edge_sync u_ext_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.din(ext_irq_pin),
		.level(ext_level),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	// Each port pin passes its own synchroniser before any compare.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			edge_sync u_port_sync (
				.sys_clk(sys_clk),
				.rst(rst),
				.din(port_b_pins[gi]),
				.level(port_sync[gi]),
				.rise(),
				.fall()
			);
		end
	endgenerate

	// Quarter-phase divider; q_end marks the Q4 slot ending each instruction cycle.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q_r <= 2'h0;
		end else begin
			q_r <= q_r + 2'h1;
		end
	end
	assign q_end = (q_r == Q_LAST);

	// Edge selection by the option register.
	assign ext_edge = option_r[EDGE_SEL_BIT] ? ext_rise : ext_fall;

	// A pin edge outside the Q4 to Q1 window is held until the window opens.
	// Edges inside the window land directly, so a software clear is not undone later.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ext_pend_r <= 1'b0;
		end else if (q_r == Q_LAST || q_r == 2'h0) begin
			ext_pend_r <= 1'b0;
		end else if (ext_edge) begin
			ext_pend_r <= 1'b1;
		end
	end

	// The port is compared against the value latched by the last port read.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port_latch_r <= 4'h0;
		end else if (port_b_read) begin
			port_latch_r <= port_sync;
		end
	end
	// A change coinciding with the read is absorbed into the new latch value.
	assign port_change = (port_sync != port_latch_r) && !port_b_read;

	// Hardware set terms for the control and peripheral flags.
	always_comb begin
		ctrl_set = 8'h00;
		ctrl_set[EXTF_BIT] = (ext_edge | ext_pend_r) && (q_r == Q_LAST || q_r == 2'h0);
		ctrl_set[TIMER_FLAG_BIT] = timer_rollover;
		ctrl_set[PCIF_BIT] = port_change;
		periph_set = 8'h00;
		periph_set[EE_BIT] = eeprom_done_evt;
		periph_set[CMP_BIT] = comparator_evt;
		periph_set[RX_BIT] = serial_rx_evt;
		periph_set[TX_BIT] = serial_tx_evt;
		periph_set[CCP_BIT] = capture_compare_evt;
		periph_set[TMR2_BIT] = timer_match_evt;
		periph_set[TMR1_BIT] = timer_b_overflow_evt;
	end

	// Control register: software writes, hardware sets win over clears, entry clears enable.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_control_r <= IRQ_CONTROL_RST;
		end else begin
			if (hit(reg_addr, IRQ_CONTROL_OFS, reg_wr)) begin
				irq_control_r <= reg_wdata | ctrl_set;
			end else begin
				irq_control_r <= irq_control_r | ctrl_set;
			end
			if (return_from_irq_instr) begin
				irq_control_r[GLOBAL_EN_BIT] <= 1'b1;
			end
			if (irq_disable_instr || state_nxt == ST_ENTER) begin
				irq_control_r[GLOBAL_EN_BIT] <= 1'b0;
			end
		end
	end

	// Peripheral flag register, kept apart from the control register.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			periph_flag_reg_r <= PERIPH_RST;
		end else if (hit(reg_addr, PERIPH_FLAG_OFS, reg_wr)) begin
			periph_flag_reg_r <= (reg_wdata | periph_set) & PERIPH_MASK;
		end else begin
			periph_flag_reg_r <= (periph_flag_reg_r | periph_set) & PERIPH_MASK;
		end
	end

	// Peripheral enable register.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			periph_enable_reg_r <= PERIPH_RST;
		end else if (hit(reg_addr, PERIPH_ENABLE_OFS, reg_wr)) begin
			periph_enable_reg_r <= reg_wdata & PERIPH_MASK;
		end
	end

	// Option register; only the edge-select bit is used here.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			option_r <= OPTION_RST;
		end else if (hit(reg_addr, OPTION_OFS, reg_wr)) begin
			option_r <= reg_wdata;
		end
	end

	// Masked request groups: each flag paired with its own enable.
	assign core_req = (irq_control_r[EXTF_BIT] & irq_control_r[EXTE_BIT])
		| (irq_control_r[TIMER_FLAG_BIT] & irq_control_r[TIMER_EN_BIT])
		| (irq_control_r[PCIF_BIT] & irq_control_r[PCIE_BIT]);
	assign periph_req = irq_control_r[PERIPH_EN_BIT]
		& (|(periph_flag_reg_r & periph_enable_reg_r));
	assign pending = core_req | periph_req;
	// Wake-up needs no global enable; an enabled pending flag wakes at once.
	assign wake = sleeping & pending;

	// Pending is sampled once per instruction cycle to give the fixed latency.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_d1_r <= 1'b0;
		end else if (q_end) begin
			pend_d1_r <= pending & irq_control_r[GLOBAL_EN_BIT] & ~sleeping;
		end
	end

	// Vectoring sequence: sample, wait one cycle, then enter on a cycle boundary.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN: begin
				if (q_end && pend_d1_r && irq_control_r[GLOBAL_EN_BIT] && !irq_disable_instr) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (irq_disable_instr || !irq_control_r[GLOBAL_EN_BIT]) begin
					state_nxt = ST_RUN;
				end else if (q_end) begin
					state_nxt = ST_ENTER;
				end
			end
			ST_ENTER: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Entry outputs: only the return address is handed to the stack.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			take_r <= 1'b0;
			vector_r <= 13'h0000;
			pushed_r <= 13'h0000;
		end else begin
			take_r <= (state_nxt == ST_ENTER);
			if (state_nxt == ST_ENTER) begin
				vector_r <= IRQ_VECTOR;
				pushed_r <= return_pc;
			end
		end
	end
	assign irq_take = take_r;
	assign push_stack = take_r;
	assign vector_pc = vector_r;
	assign pushed_pc = pushed_r;

	// A no-op slot follows an instruction that clears the global enable.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nop_r <= 1'b0;
		end else begin
			nop_r <= irq_disable_instr;
		end
	end
	assign nop_slot = nop_r;

	// Read port: data stands in the cycle after the read strobe; unmapped reads zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				IRQ_CONTROL_OFS: rdata_r <= irq_control_r;
				PERIPH_FLAG_OFS: rdata_r <= periph_flag_reg_r;
				PERIPH_ENABLE_OFS: rdata_r <= periph_enable_reg_r;
				OPTION_OFS: rdata_r <= option_r;
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end
	assign reg_rdata = rdata_r;

	logic unused_ok;
	assign unused_ok = ext_level;
endmodule
`default_nettype wire

// ==== shared/irq_ctrl_pkg.sv ====
// Package of register offsets, bit positions, reset values and timing constants for the interrupt controller.
package irq_ctrl_pkg;
	// Register offsets as seen on the register port.
	localparam logic [7:0] IRQ_CONTROL_OFS = 8'h0B;
	localparam logic [7:0] PERIPH_FLAG_OFS = 8'h0C;
	localparam logic [7:0] PERIPH_ENABLE_OFS = 8'h8C;
	localparam logic [7:0] OPTION_OFS = 8'h81;
	// Control register bit positions.
	localparam int GLOBAL_EN_BIT = 7;
	localparam int PERIPH_EN_BIT = 6;
	localparam int TIMER_EN_BIT = 5;
	localparam int EXTE_BIT = 4;
	localparam int PCIE_BIT = 3;
	localparam int TIMER_FLAG_BIT = 2;
	localparam int EXTF_BIT = 1;
	localparam int PCIF_BIT = 0;
	// Peripheral flag bit positions.
	localparam int EE_BIT = 7;
	localparam int CMP_BIT = 6;
	localparam int RX_BIT = 5;
	localparam int TX_BIT = 4;
	localparam int CCP_BIT = 2;
	localparam int TMR2_BIT = 1;
	localparam int TMR1_BIT = 0;
	// Option register edge-select bit.
	localparam int EDGE_SEL_BIT = 6;
	// Reset values; bit 3 of the peripheral registers is unimplemented.
	localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
	localparam logic [7:0] PERIPH_RST = 8'h00;
	localparam logic [7:0] PERIPH_MASK = 8'hF7;
	localparam logic [7:0] OPTION_RST = 8'hFF;
	// Interrupt vector and index of the last quarter-phase per instruction cycle.
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam int NUM_SOURCES = 10;
endpackage

// ==== rtl/edge_sync.sv ====
// Two-flop synchroniser with an edge detector behind the second stage.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic din,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// Only the second stage reads the first; edges come from stages two and three.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign level = s2_r;
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;
endmodule
`default_nettype wire

// ==== testbench/irq_controller_sva.sv ====
// Port-level timing checker for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module irq_controller_sva
	import irq_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic irq_disable_instr,
	input wire logic sleeping,
	input wire logic [12:0] return_pc,
	input wire logic q_end,
	input wire logic irq_take,
	input wire logic [12:0] vector_pc,
	input wire logic [12:0] pushed_pc,
	input wire logic push_stack,
	input wire logic nop_slot,
	input wire logic wake
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_take_vector: assert property (irq_take |=> vector_pc == IRQ_VECTOR)
		else $error("vector address wrong after entry");
	a_take_push: assert property (irq_take == push_stack)
		else $error("stack push not paired with entry");
	a_take_single: assert property (irq_take |=> !irq_take)
		else $error("entry pulse longer than one cycle");
	a_push_return: assert property (irq_take |-> pushed_pc == $past(return_pc))
		else $error("pushed address differs from return address");
	a_nop_after: assert property (irq_disable_instr |=> nop_slot)
		else $error("no-op slot missing after enable clear");
	a_q_period: assert property (q_end |=> !q_end ##1 !q_end ##1 !q_end ##1 q_end)
		else $error("instruction cycle is not four clocks");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_unmapped_rd: assert property (reg_rd && !(reg_addr inside {8'h0B, 8'h0C, 8'h8C, 8'h81})
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_wake_sleep: assert property (wake |-> sleeping)
		else $error("wake while not sleeping");
endmodule
bind irq_controller irq_controller_sva u_irq_controller_sva (.sys_clk(sys_clk), .rst(rst),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.irq_disable_instr(irq_disable_instr), .sleeping(sleeping), .return_pc(return_pc),
	.q_end(q_end), .irq_take(irq_take), .vector_pc(vector_pc), .pushed_pc(pushed_pc),
	.push_stack(push_stack), .nop_slot(nop_slot), .wake(wake));
`default_nettype wire

// ==== testbench/core_seq_model.sv ====
// Behavioural model of the core sequencer facing the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic q_end,
	input wire logic irq_take,
	input wire logic wake,
	input wire logic go_sleep,
	output logic [12:0] return_pc,
	output logic sleeping
);
	// The program counter steps once per instruction cycle and jumps on entry.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			return_pc <= 13'h0000;
		end else if (irq_take) begin
			return_pc <= 13'h0004;
		end else if (q_end) begin
			return_pc <= return_pc + 13'h0001;
		end
	end
	// Sleep starts on request and ends when the controller wakes the core.
	always_ff @(posedge sys_clk) begin
		if (rst || wake) begin
			sleeping <= 1'b0;
		end else if (go_sleep) begin
			sleeping <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/irq_controller_tb_top.sv ====
// Self-checking bench of the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module irq_controller_tb_top
	import irq_ctrl_pkg::*;
;
	logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ext_pin = 0, pb_rd = 0, tro = 0;
	logic gclr = 0, rfi = 0, go_sleep = 0;
	logic [7:0] addr = 0, wdata = 0, v, reg_rdata;
	logic [3:0] pb = 0;
	logic [6:0] pev = 0;
	logic [31:0] seed = 32'h02475E6F;
	wire logic [12:0] return_pc, vector_pc, pushed_pc;
	wire logic sleeping, q_end, irq_take, push_stack, nop_slot, wake;
	int n_mismatch = 0, compares = 0, n_take = 0, n, t0;
	irq_controller u_irq_controller (.sys_clk(sys_clk), .rst(rst), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_irq_pin(ext_pin), .port_b_pins(pb), .port_b_read(pb_rd), .timer_rollover(tro),
		.comparator_evt(pev[5]), .serial_tx_evt(pev[3]), .serial_rx_evt(pev[4]),
		.capture_compare_evt(pev[2]), .timer_b_overflow_evt(pev[0]),
		.timer_match_evt(pev[1]), .eeprom_done_evt(pev[6]), .irq_disable_instr(gclr),
		.return_from_irq_instr(rfi), .sleeping(sleeping), .return_pc(return_pc),
		.q_end(q_end), .irq_take(irq_take), .vector_pc(vector_pc), .pushed_pc(pushed_pc),
		.push_stack(push_stack), .nop_slot(nop_slot), .wake(wake));
	core_seq_model u_core_seq_model (.sys_clk(sys_clk), .rst(rst), .q_end(q_end),
		.irq_take(irq_take), .wake(wake), .go_sleep(go_sleep), .return_pc(return_pc),
		.sleeping(sleeping));
	// Clock of 8 ns period and a tally of entries.
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (irq_take === 1'b1) n_take++;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task end_sim;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// Register port cycles: one-cycle strobes, read data one cycle later.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task ck(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("register", e, reg_rdata);
	endtask
	task idle(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	task wtake;
		n = 0;
		while (irq_take !== 1'b1 && n < 40) begin
			idle(1);
			n++;
		end
		if (n == 40) begin
			n_mismatch++;
			$display("ERROR irq_take expected 1 seen 0");
			end_sim;
		end
	endtask
	// Main sequence.
	initial begin
		idle(10);
		rst <= 1'b0;
		ck(IRQ_CONTROL_OFS, IRQ_CONTROL_RST);
		ck(PERIPH_FLAG_OFS, PERIPH_RST);
		ck(PERIPH_ENABLE_OFS, PERIPH_RST);
		ck(OPTION_OFS, OPTION_RST);
		wr(8'h5A, 8'hFF);
		ck(8'h5A, 8'h00);
		repeat (4) begin
			seed = lfsr(seed);
			wr(PERIPH_ENABLE_OFS, seed[7:0]);
			ck(PERIPH_ENABLE_OFS, seed[7:0] & PERIPH_MASK);
		end
		wr(PERIPH_ENABLE_OFS, 8'h00);
		// All ten sources fire with every enable off.
		pev <= 7'h7F;
		tro <= 1'b1;
		ext_pin <= 1'b1;
		pb <= 4'hF;
		@(posedge sys_clk);
		pev <= 7'h00;
		tro <= 1'b0;
		idle(12);
		// A port read latches the new pin value, so the change flag can be cleared later.
		@(posedge sys_clk);
		pb_rd <= 1'b1;
		@(posedge sys_clk);
		pb_rd <= 1'b0;
		ck(IRQ_CONTROL_OFS, 8'h07);
		ck(PERIPH_FLAG_OFS, 8'hF7);
		t0 = n_take;
		wr(IRQ_CONTROL_OFS, 8'hC7);
		idle(20);
		chk("masked takes", t0, n_take);
		wr(IRQ_CONTROL_OFS, 8'hA7);
		wtake;
		ck(IRQ_CONTROL_OFS, 8'h27);
		wr(IRQ_CONTROL_OFS, 8'h20);
		@(posedge sys_clk);
		rfi <= 1'b1;
		@(posedge sys_clk);
		rfi <= 1'b0;
		ck(IRQ_CONTROL_OFS, 8'hA0);
		// Enable cleared by an instruction while the timer rolls over.
		@(posedge sys_clk);
		gclr <= 1'b1;
		tro <= 1'b1;
		addr <= IRQ_CONTROL_OFS;
		wdata <= 8'hA0; // The write keeps the enable set; only the instruction clears it.
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		gclr <= 1'b0;
		tro <= 1'b0;
		reg_wr <= 1'b0;
		t0 = n_take;
		idle(20);
		chk("ignored takes", t0, n_take);
		ck(IRQ_CONTROL_OFS, 8'h24);
		wr(IRQ_CONTROL_OFS, 8'hA4);
		wtake;
		wr(IRQ_CONTROL_OFS, 8'h00);
		ext_pin <= 1'b0;
		idle(12);
		ck(IRQ_CONTROL_OFS, 8'h00);
		wr(OPTION_OFS, 8'hBF);
		ext_pin <= 1'b1;
		idle(12);
		ck(IRQ_CONTROL_OFS, 8'h00);
		ext_pin <= 1'b0;
		idle(12);
		ck(IRQ_CONTROL_OFS, 8'h02);
		wr(IRQ_CONTROL_OFS, 8'h90);
		ext_pin <= 1'b1;
		idle(12);
		ext_pin <= 1'b0;
		wtake;
		chk("pin latency ok", 8'h01, {7'h00, n >= 8 && n <= 20});
		// Port change wakes a sleeping core with the global enable clear.
		wr(IRQ_CONTROL_OFS, 8'h08);
		t0 = n_take;
		go_sleep <= 1'b1;
		pb_rd <= 1'b1;
		@(posedge sys_clk);
		go_sleep <= 1'b0;
		pb_rd <= 1'b0;
		pb <= 4'h7;
		idle(16);
		chk("sleeping", 8'h00, {7'h00, sleeping});
		chk("woken takes", t0, n_take);
		ck(IRQ_CONTROL_OFS, 8'h09);
		// Comparator through the peripheral path.
		wr(PERIPH_FLAG_OFS, 8'h00);
		wr(PERIPH_ENABLE_OFS, 8'h40);
		wr(IRQ_CONTROL_OFS, 8'hC0);
		pev <= 7'h20;
		@(posedge sys_clk);
		pev <= 7'h00;
		wtake;
		ck(PERIPH_FLAG_OFS, 8'h40);
		end_sim;
	end
endmodule
`default_nettype wire
